// File: verilog/dolc_top.sv
// diagnostic output multiplexer and load-adaptive fullstep commutation control
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dolc_top
#(
    parameter int FLOOR_W = 24
)
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // motor side
    input wire dolc_pkg::dolc_motor_t motor,
    input wire logic step_dir_select,
    input wire logic commutation_enable_input,
    input wire logic step_request,
    input wire logic motor_step_ready,
    // ramp generator side
    input wire dolc_pkg::dolc_ramp_t ramp,
    output logic [22:0] ramp_current_velocity,
    // commutation outputs
    output logic step_execute,
    output logic fullstep_mode,
    output dolc_pkg::dolc_meas_t meas_cfg,
    // diagnostic pins
    output logic diag_pin_first_out,
    output logic diag_pin_first_oe_n,
    output logic diag_pin_second_out,
    output logic diag_pin_second_oe_n
);
    import dolc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] diag_cfg;
    logic [22:0] min_commutation_velocity;
    logic [19:0] energy_save_velocity_threshold;
    logic [9:0] load_ref_pulse_width;
    logic [7:0] commutation_stall_sensitivity;
    logic [FLOOR_W-1:0] floor_step_period;
    logic pos_reached_event;
    logic stall_stop_event;
    logic ack;
    logic wr_take;
    logic rd_take;
    logic stat_read;

    // status signals
    logic stall;
    logic index_flag;
    logic chop_sel;
    logic chop_state;
    logic skipped_toggle;
    logic commutation_active;
    logic above_min;
    logic [FLOOR_W-1:0] wait_count;
    logic floor_due;
    logic [31:0] next_readdata;

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the request is taken
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_take = avs_write & ack & clk_en;
    assign rd_take = avs_read & ack & clk_en;
    assign stat_read = rd_take & (avs_address == DOLC_OFS_RAMP_STAT);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ack <= 1'b0;
        else if (clk_en)
            ack <= (avs_read | avs_write) & ~ack;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration writes
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            diag_cfg <= DOLC_RST_DIAG_CFG;
            min_commutation_velocity <= DOLC_RST_MIN_VEL;
            energy_save_velocity_threshold <= DOLC_RST_SAVE_THR;
            load_ref_pulse_width <= DOLC_RST_REF_WIDTH;
            commutation_stall_sensitivity <= DOLC_RST_SENS;
            floor_step_period <= FLOOR_W'(DOLC_RST_FLOOR_PER);
        end
        else if (wr_take)
        begin
            if (avs_address == DOLC_OFS_DIAG_CFG)
                diag_cfg <= avs_writedata & 32'h0000_F1FF;
            else if (avs_address == DOLC_OFS_MIN_VEL)
                min_commutation_velocity <= avs_writedata[22:0];
            else if (avs_address == DOLC_OFS_SAVE_THR)
                energy_save_velocity_threshold <= avs_writedata[19:0];
            else if (avs_address == DOLC_OFS_LOAD_CFG)
            begin
                load_ref_pulse_width <= avs_writedata[9:0];
                commutation_stall_sensitivity <= avs_writedata[DOLC_LCFG_SENS_LSB +: 8];
            end
            else if (avs_address == DOLC_OFS_FLOOR_PER)
                floor_step_period <= avs_writedata[FLOOR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, registered at the wait cycle so it stands at the taking edge
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (avs_address == DOLC_OFS_DIAG_CFG)
            next_readdata = diag_cfg;
        else if (avs_address == DOLC_OFS_MIN_VEL)
            next_readdata = {9'h000, min_commutation_velocity};
        else if (avs_address == DOLC_OFS_SAVE_THR)
            next_readdata = {12'h000, energy_save_velocity_threshold};
        else if (avs_address == DOLC_OFS_LOAD_CFG)
            next_readdata = {8'h00, commutation_stall_sensitivity, 6'h00, load_ref_pulse_width};
        else if (avs_address == DOLC_OFS_FLOOR_PER)
            next_readdata = 32'(floor_step_period);
        else if (avs_address == DOLC_OFS_RAMP_STAT)
            next_readdata = {29'h0000_0000, stall, stall_stop_event, pos_reached_event};
        else if (avs_address == DOLC_OFS_STATUS)
            next_readdata = {16'h0000, 2'h0, fullstep_mode, commutation_active,
                skipped_toggle, index_flag, stall, motor.load_measure_value};
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            avs_readdata <= 32'h0000_0000;
        else if (clk_en && avs_read && !ack)
            avs_readdata <= next_readdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ramp status events; set wins over the clear-on-read
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pos_reached_event <= 1'b1;
        else if (clk_en)
        begin
            if (ramp.pos_reached)
                pos_reached_event <= 1'b1;
            else if (stat_read)
                pos_reached_event <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            stall_stop_event <= 1'b0;
        else if (clk_en)
        begin
            if (stall && commutation_active && diag_cfg[DOLC_CFG_STOP])
                stall_stop_event <= 1'b1;
            else if (stat_read)
                stall_stop_event <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // diagnostic sources
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            stall <= 1'b0;
            index_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            stall <= (motor.load_measure_value == 9'h000) &&
                (motor.measured_step_period <= energy_save_velocity_threshold);
            // follows the counter, so it spans one microstep however short
            index_flag <= (motor.microstep_counter == 10'h000);
        end
    end

    // the shown coil hands over in each cycle that it is not in its on phase and the voltage chopper is off
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            chop_sel <= 1'b0;
        else if (clk_en && !chop_state && !motor.voltage_chopper_active)
            chop_sel <= ~chop_sel;
    end

    always_comb
    begin
        if (motor.voltage_chopper_active)
            chop_state = 1'b0;
        else if (chop_sel)
            chop_state = motor.chop_on_b;
        else
            chop_state = motor.chop_on_a;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // commutation enable and fullstep switching
    always_comb
    begin
        above_min = (min_commutation_velocity != 23'h00_0000) &&
            (ramp.target_velocity > min_commutation_velocity);
        if (motor.voltage_chopper_active)
            commutation_active = 1'b0;
        else if (step_dir_select)
            commutation_active = commutation_enable_input;
        else
            commutation_active = above_min;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            fullstep_mode <= 1'b0;
        else if (clk_en)
            fullstep_mode <= commutation_active && diag_cfg[DOLC_CFG_VHIGHFS] &&
                diag_cfg[DOLC_CFG_VHIGHCHM];
    end

    // off time saturates at eight while commutating
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            meas_cfg <= '0;
        else if (clk_en)
        begin
            meas_cfg.load_ref_pulse_width <= load_ref_pulse_width;
            meas_cfg.commutation_stall_sensitivity <= commutation_stall_sensitivity;
            if (commutation_active && diag_cfg[DOLC_CFG_CHOPPER_OFF_TIME_LSB +: 4] > DOLC_CHOPPER_OFF_TIME_CAP)
                meas_cfg.chopper_off_time <= DOLC_CHOPPER_OFF_TIME_CAP;
            else
                meas_cfg.chopper_off_time <= diag_cfg[DOLC_CFG_CHOPPER_OFF_TIME_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // step execution: in fullstep with no stall stop pending, a requested step runs only if the motor is ready, the floor period forces one
    assign floor_due = (wait_count >= floor_step_period);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            step_execute <= 1'b0;
        else if (clk_en)
        begin
            if (!fullstep_mode)
                step_execute <= step_request;
            else if (stall_stop_event)
                step_execute <= 1'b0;
            else if (step_request && motor_step_ready)
                step_execute <= 1'b1;
            else
                step_execute <= floor_due;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            wait_count <= '0;
        else if (clk_en)
        begin
            if (!fullstep_mode || step_execute)
                wait_count <= '0;
            else if (!floor_due)
                wait_count <= wait_count + FLOOR_W'(1);
        end
    end

    // each request in fullstep that the sequencer cannot take flips the level
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            skipped_toggle <= 1'b0;
        else if (clk_en && fullstep_mode && step_request && !motor_step_ready)
            skipped_toggle <= ~skipped_toggle;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ramp_current_velocity <= 23'h00_0000;
        else if (clk_en)
            ramp_current_velocity <= stall_stop_event ? 23'h00_0000 : ramp.target_velocity;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // diagnostic pins; ramp mode uses interrupt and compare
    logic [3:0] src_first;
    logic [3:0] src_second;
    logic irq_level;
    logic [1:0] sel_first;
    logic [1:0] sel_second;

    assign irq_level = pos_reached_event | stall_stop_event | ramp.ramp_irq;
    assign src_first = step_dir_select ?
        {skipped_toggle, chop_state, index_flag, stall} : {4{irq_level}};
    assign src_second = step_dir_select ?
        {skipped_toggle, chop_state, index_flag, stall} : {4{ramp.pos_compare}};
    assign sel_first = diag_cfg[DOLC_CFG_SRC0_LSB +: 2];
    assign sel_second = diag_cfg[DOLC_CFG_SRC1_LSB +: 2];

    dolc_diag_pin u_pin_first
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .sources(src_first),
        .select(sel_first),
        .push_pull(diag_cfg[DOLC_CFG_PP0]),
        .force_low(reset),
        .pin_out(diag_pin_first_out),
        .pin_oe_n(diag_pin_first_oe_n)
    );

    dolc_diag_pin u_pin_second
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .sources(src_second),
        .select(sel_second),
        .push_pull(diag_cfg[DOLC_CFG_PP1]),
        .force_low(1'b0),
        .pin_out(diag_pin_second_out),
        .pin_oe_n(diag_pin_second_oe_n)
    );
endmodule // dolc_top
`default_nettype wire

// File: shared/dolc_pkg.sv
// constants, register map and carrier types of the diagnostic output and commutation block
package dolc_pkg;
    // register byte offsets
    localparam logic [4:0] DOLC_OFS_DIAG_CFG = 5'h00;
    localparam logic [4:0] DOLC_OFS_MIN_VEL = 5'h04;
    localparam logic [4:0] DOLC_OFS_SAVE_THR = 5'h08;
    localparam logic [4:0] DOLC_OFS_LOAD_CFG = 5'h0C;
    localparam logic [4:0] DOLC_OFS_FLOOR_PER = 5'h10;
    localparam logic [4:0] DOLC_OFS_RAMP_STAT = 5'h14;
    localparam logic [4:0] DOLC_OFS_STATUS = 5'h18;
    // diag_cfg field positions
    localparam int DOLC_CFG_SRC0_LSB = 0;
    localparam int DOLC_CFG_SRC1_LSB = 2;
    localparam int DOLC_CFG_PP0 = 4;
    localparam int DOLC_CFG_PP1 = 5;
    localparam int DOLC_CFG_STOP = 6;
    localparam int DOLC_CFG_VHIGHFS = 7;
    localparam int DOLC_CFG_VHIGHCHM = 8;
    localparam int DOLC_CFG_CHOPPER_OFF_TIME_LSB = 12;
    // load_cfg field positions
    localparam int DOLC_LCFG_SENS_LSB = 16;
    // reset values
    localparam logic [31:0] DOLC_RST_DIAG_CFG = 32'h0000_3000;
    localparam logic [22:0] DOLC_RST_MIN_VEL = 23'h00_0000;
    localparam logic [19:0] DOLC_RST_SAVE_THR = 20'h0_0000;
    localparam logic [9:0] DOLC_RST_REF_WIDTH = 10'h000;
    localparam logic [7:0] DOLC_RST_SENS = 8'h00;
    localparam logic [23:0] DOLC_RST_FLOOR_PER = 24'hFF_FFFF;
    // off time saturation under load-adaptive commutation
    localparam logic [3:0] DOLC_CHOPPER_OFF_TIME_CAP = 4'h8;
    // diagnostic source codes
    typedef enum logic [1:0] {
        DOLC_SRC_STALL = 2'b00,
        DOLC_SRC_INDEX = 2'b01,
        DOLC_SRC_CHOP = 2'b10,
        DOLC_SRC_SKIP = 2'b11
    } dolc_src_t;
    // sampled motor-side inputs
    typedef struct packed {
        logic [8:0] load_measure_value;
        logic [19:0] measured_step_period;
        logic [9:0] microstep_counter;
        logic chop_on_a;
        logic chop_on_b;
        logic voltage_chopper_active;
    } dolc_motor_t;
    // ramp generator side inputs
    typedef struct packed {
        logic [22:0] target_velocity;
        logic pos_compare;
        logic pos_reached;
        logic ramp_irq;
    } dolc_ramp_t;
    // analog measurement settings out
    typedef struct packed {
        logic [9:0] load_ref_pulse_width;
        logic [7:0] commutation_stall_sensitivity;
        logic [3:0] chopper_off_time;
    } dolc_meas_t;
endpackage

// File: verilog/dolc_diag_pin.sv
// one diagnostic pin: registered source select and drive type
`timescale 1ns/10ps
`default_nettype none
module dolc_diag_pin
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // sources and setup
    input wire logic [3:0] sources,
    input wire logic [1:0] select,
    input wire logic push_pull,
    input wire logic force_low,
    // pin
    output logic pin_out,
    output logic pin_oe_n
);
    import dolc_pkg::*;

    logic active;

    // one flop per pin so a source change never glitches the pad
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            active <= force_low;
        else if (clk_en)
            active <= sources[select];
    end

    // open drain: drive low when active; push-pull: drive high when active
    always_comb
    begin
        if (force_low)
        begin
            pin_out = 1'b0;
            pin_oe_n = 1'b0;
        end
        else if (push_pull)
        begin
            pin_out = active;
            pin_oe_n = 1'b0;
        end
        else
        begin
            pin_out = 1'b0;
            pin_oe_n = ~active;
        end
    end
endmodule // dolc_diag_pin
`default_nettype wire

// File: bench/dolc_props.sv
// assertion checker for the diagnostic output and commutation block
`timescale 1ns/10ps
`default_nettype none
module dolc_props
#(
    parameter int FLOOR_W = 24
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // motor and ramp side
    input wire dolc_pkg::dolc_motor_t motor,
    input wire dolc_pkg::dolc_ramp_t ramp,
    input wire logic step_dir_select,
    input wire logic commutation_enable_input,
    input wire logic step_request,
    input wire logic motor_step_ready,
    input wire logic [22:0] ramp_current_velocity,
    input wire logic step_execute,
    input wire logic fullstep_mode,
    // pins
    input wire logic diag_pin_first_out,
    input wire logic diag_pin_first_oe_n,
    input wire logic diag_pin_second_out,
    input wire logic diag_pin_second_oe_n
);
    import dolc_pkg::*;
    logic [8:0] cfg;
    logic [19:0] thr;
    logic wr_ok;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    assign wr_ok = avs_write && !avs_waitrequest && clk_en;
    // shadow of the setup words so the pin checks know the routing
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg <= DOLC_RST_DIAG_CFG[8:0];
        else if (wr_ok && avs_address == DOLC_OFS_DIAG_CFG)
            cfg <= avs_writedata[8:0];
    end
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            thr <= DOLC_RST_SAVE_THR;
        else if (wr_ok && avs_address == DOLC_OFS_SAVE_THR)
            thr <= avs_writedata[19:0];
    end
    ////////////////////////////////////////////////////////////////////////////
    // reset itself must be seen, so no disable here
    a_reset_pin_low: assert property (disable iff (1'b0) reset ##1 reset |->
        !diag_pin_first_out && !diag_pin_first_oe_n) else $error("first pin not low in reset");
    a_bus_one_wait: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
    a_step_taken: assert property (step_request && motor_step_ready |=> step_execute)
        else $error("ready step not executed");
    a_step_skipped: assert property (fullstep_mode && step_request && !motor_step_ready
        |=> !step_execute) else $error("blocked step executed");
    a_vel_follows: assert property (1'b1 |=> ramp_current_velocity == $past(ramp.target_velocity)
        || ramp_current_velocity == 23'h0) else $error("velocity neither target nor zero");
    a_index_pin: assert property ((step_dir_select && cfg[3:2] == DOLC_SRC_INDEX && cfg[5]
        && motor.microstep_counter == 10'h0)[*4] |-> diag_pin_second_out && !diag_pin_second_oe_n)
        else $error("index not shown");
    a_stall_pin: assert property ((step_dir_select && !commutation_enable_input
        && cfg[1:0] == DOLC_SRC_STALL && cfg[4] && motor.load_measure_value == 9'h0
        && motor.measured_step_period <= thr)[*4] |-> diag_pin_first_out)
        else $error("stall not shown");
    a_irq_pin: assert property ((!step_dir_select && cfg[4] && ramp.ramp_irq)[*4]
        |-> diag_pin_first_out) else $error("ramp interrupt not shown");
    a_flags_needed: assert property ((!(cfg[7] && cfg[8]))[*4] |-> !fullstep_mode)
        else $error("fullstep without chopper flags");
    a_voltage_off: assert property ((motor.voltage_chopper_active)[*4] |-> !fullstep_mode)
        else $error("fullstep under voltage chopper");
endmodule // dolc_props
bind dolc_top dolc_props #(.FLOOR_W(FLOOR_W)) dolc_props_inst
(
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .motor(motor), .ramp(ramp),
    .step_dir_select(step_dir_select), .commutation_enable_input(commutation_enable_input),
    .step_request(step_request), .motor_step_ready(motor_step_ready),
    .ramp_current_velocity(ramp_current_velocity), .step_execute(step_execute),
    .fullstep_mode(fullstep_mode), .diag_pin_first_out(diag_pin_first_out),
    .diag_pin_first_oe_n(diag_pin_first_oe_n), .diag_pin_second_out(diag_pin_second_out),
    .diag_pin_second_oe_n(diag_pin_second_oe_n)
);
`default_nettype wire

// File: bench/dolc_partner.sv
// behavioural external motion controller facing the diagnostic pins
`timescale 1ns/10ps
`default_nettype none
module dolc_partner
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // command from the bench
    input wire logic want_commutation,
    // towards the block
    output logic step_request,
    output logic commutation_enable_input,
    // pins as seen on the board
    input wire logic first_out,
    input wire logic first_oe_n,
    input wire logic second_out,
    input wire logic second_oe_n,
    output logic first_level,
    output logic second_level
);
    // board pull-ups lift a released open-drain line
    assign first_level = first_oe_n ? 1'b1 : first_out;
    assign second_level = second_oe_n ? 1'b1 : second_out;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            commutation_enable_input <= 1'b0;
        else
            commutation_enable_input <= want_commutation;
    end
    initial
        step_request = 1'b0;
    // one-cycle pulses with a quiet cycle between them
    task automatic issue_steps(input int count);
        repeat (count)
        begin
            @(posedge sys_clk);
            step_request <= 1'b1;
            @(posedge sys_clk);
            step_request <= 1'b0;
        end
    endtask
endmodule // dolc_partner
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the diagnostic output and commutation block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dolc_pkg::*;
    logic sys_clk, reset, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    dolc_motor_t motor;
    dolc_ramp_t ramp;
    dolc_meas_t meas_cfg;
    logic step_dir_select, want_comm, comm_en, step_request, motor_step_ready;
    logic [22:0] ramp_current_velocity;
    logic step_execute, fullstep_mode, d1_out, d1_oe_n, d2_out, d2_oe_n, lvl1, lvl2;
    int mismatches, samples_checked, cycles;
    dolc_top #(.FLOOR_W(24)) dolc_top_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .motor(motor), .step_dir_select(step_dir_select),
        .commutation_enable_input(comm_en), .step_request(step_request),
        .motor_step_ready(motor_step_ready), .ramp(ramp),
        .ramp_current_velocity(ramp_current_velocity), .step_execute(step_execute),
        .fullstep_mode(fullstep_mode), .meas_cfg(meas_cfg), .diag_pin_first_out(d1_out),
        .diag_pin_first_oe_n(d1_oe_n), .diag_pin_second_out(d2_out),
        .diag_pin_second_oe_n(d2_oe_n));
    dolc_partner dolc_partner_inst (.sys_clk(sys_clk), .reset(reset),
        .want_commutation(want_comm), .step_request(step_request),
        .commutation_enable_input(comm_en), .first_out(d1_out), .first_oe_n(d1_oe_n),
        .second_out(d2_out), .second_oe_n(d2_oe_n), .first_level(lvl1), .second_level(lvl2));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // request held until the edge where waitrequest is low
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [4:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard; the full sequence needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        {reset, clk_en, motor_step_ready} = 3'b111;
        {avs_read, avs_write, step_dir_select, want_comm} = 4'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        {mismatches, samples_checked, cycles} = {32'h0, 32'h0, 32'h0};
        ramp = '0;
        motor = '0;
        motor.load_measure_value = 9'h1FF;
        motor.measured_step_period = 20'hF_FFFF;
        motor.microstep_counter = 10'h001;
        wt(5);
        chk("pin in reset", 32'h0, {30'h0, d1_out, d1_oe_n});
        repeat (7) @(posedge sys_clk);
        reset <= 1'b0;
        wt(2);
        chk("pin after reset", 32'h0, {31'h0, d1_oe_n});
        rchk("ramp status", DOLC_OFS_RAMP_STAT, 32'h1);
        wt(3);
        chk("pin released", 32'h1, {31'h0, lvl1});
        rchk("diag cfg", DOLC_OFS_DIAG_CFG, DOLC_RST_DIAG_CFG);
        rchk("floor", DOLC_OFS_FLOOR_PER, {8'h00, DOLC_RST_FLOOR_PER});
        rchk("unmapped", 5'h1C, 32'h0);
        bus(1'b1, DOLC_OFS_DIAG_CFG, 32'h0000_3030);
        @(posedge sys_clk);
        {ramp.ramp_irq, ramp.pos_compare} <= 2'b11;
        wt(4);
        chk("ramp pins on", 32'h3, {30'h0, lvl1, lvl2});
        @(posedge sys_clk);
        {ramp.ramp_irq, ramp.pos_compare} <= 2'b00;
        wt(4);
        chk("ramp pins off", 32'h0, {30'h0, lvl1, lvl2});
        bus(1'b1, DOLC_OFS_MIN_VEL, 32'h0000_0064);
        bus(1'b1, DOLC_OFS_SAVE_THR, 32'h0000_00C8);
        bus(1'b1, DOLC_OFS_DIAG_CFG, 32'h0000_31F0);
        @(posedge sys_clk);
        ramp.target_velocity <= 23'h32;
        wt(4);
        chk("below minimum", 32'h0, {31'h0, fullstep_mode});
        @(posedge sys_clk);
        ramp.target_velocity <= 23'h96;
        wt(4);
        chk("ramp run", 32'h0080_0096, {8'h0, fullstep_mode, ramp_current_velocity});
        @(posedge sys_clk);
        motor.load_measure_value <= 9'h0;
        motor.measured_step_period <= 20'h64;
        wt(4);
        chk("stall stop", 32'h0080_0000, {8'h0, lvl1, ramp_current_velocity});
        @(posedge sys_clk);
        motor.load_measure_value <= 9'h1FF;
        motor.measured_step_period <= 20'hF_FFFF;
        wt(4);
        chk("stop held", 32'h0, {9'h0, ramp_current_velocity});
        rchk("stall flags", DOLC_OFS_RAMP_STAT, 32'h2);
        wt(3);
        chk("resumed", 32'h96, {9'h0, ramp_current_velocity});
        @(posedge sys_clk);
        motor.voltage_chopper_active <= 1'b1;
        wt(4);
        chk("voltage chopper", 32'h0, {31'h0, fullstep_mode});
        @(posedge sys_clk);
        motor.voltage_chopper_active <= 1'b0;
        bus(1'b1, DOLC_OFS_MIN_VEL, 32'h0);
        wt(4);
        chk("minimum zero", 32'h0, {31'h0, fullstep_mode});
        rchk("status", DOLC_OFS_STATUS, 32'h0000_01FF);
        @(posedge sys_clk);
        step_dir_select <= 1'b1;
        motor.microstep_counter <= 10'h000;
        bus(1'b1, DOLC_OFS_LOAD_CFG, 32'h00FF_03FF);
        bus(1'b1, DOLC_OFS_DIAG_CFG, 32'h0000_F1B4);
        wt(4);
        chk("index on", 32'h1, {31'h0, lvl2});
        @(posedge sys_clk);
        motor.microstep_counter <= 10'h005;
        motor.load_measure_value <= 9'h0;
        motor.measured_step_period <= 20'hC8;
        wt(4);
        chk("index off stall on", 32'h2, {30'h0, lvl1, lvl2});
        @(posedge sys_clk);
        motor.measured_step_period <= 20'hC9;
        wt(4);
        chk("stall off", 32'h0, {31'h0, lvl1});
        @(posedge sys_clk);
        want_comm <= 1'b1;
        motor.load_measure_value <= 9'h1FF;
        wt(5);
        chk("forced fullstep", 32'h1, {31'h0, fullstep_mode});
        chk("meas cfg", {10'h0, 10'h3FF, 8'hFF, 4'h8}, {10'h0, meas_cfg});
        bus(1'b1, DOLC_OFS_DIAG_CFG, 32'h0000_F1BC);
        @(posedge sys_clk);
        motor_step_ready <= 1'b0;
        dolc_partner_inst.issue_steps(3);
        wt(3);
        chk("skipped odd", 32'h1, {31'h0, lvl2});
        @(posedge sys_clk);
        motor_step_ready <= 1'b1;
        dolc_partner_inst.issue_steps(2);
        wt(3);
        chk("taken steps", 32'h1, {31'h0, lvl2});
        summarize();
    end
endmodule // testbench
`default_nettype wire
